// >>> src/low_power_mode_control.sv
// Wait/stop mode controller with clock gating, wake logic and supply monitor flag
//
// Added by the designer: the register addresses and the AHB-Lite slave port.
`timescale 1ns/1ps
`default_nettype none
`include "lpm_map.svh"
module low_power_mode_control #(
    parameter int RECOVERY_LONG = `LPM_RECOVERY_LONG,
    parameter int RECOVERY_SHORT = `LPM_RECOVERY_SHORT
) (
    // Clock, reset, freeze
    input wire logic clock,
    input wire logic rst,
    input wire logic clk_en,
    // AHB-Lite slave
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic hreadyout,
    output logic hresp,
    output logic [31:0] hrdata,
    // CPU instruction events and interrupt mask
    input wire logic wait_exec,
    input wire logic stop_exec,
    input wire logic cpu_irq_mask_set,
    input wire logic cpu_irq_mask_clr,
    output logic cpu_irq_mask,
    // Wake requests and clock generator events
    input wire lpm_pkg::wake_req_t wake_req,
    input wire logic ext_clock_stable_set,
    input wire logic int_clock_stable_set,
    input wire logic clock_monitor_event,
    // Supply comparator, asynchronous
    input wire logic supply_below_fall,
    input wire logic supply_above_rise,
    output logic supply_reset_req,
    // Clock gating and peripheral mode indications
    output lpm_pkg::clk_gate_t clk_gate,
    output lpm_pkg::periph_mode_t periph_mode
);
    localparam int REC_W = $clog2(RECOVERY_LONG + 1);

    lpm_pkg::lpm_state_t state_reg;
    lpm_pkg::lpm_state_t state_next;
    lpm_pkg::clk_gate_t gate_next;
    lpm_pkg::periph_mode_t mode_next;
    logic [7:0] cfg1_reg;
    logic [7:0] cfg2_reg;
    logic [7:0] mask_reg;
    logic [7:0] clkgen_reg;
    logic brk_flag_reg;
    logic supply_low_flag;
    logic [1:0] below_sync_reg;
    logic [1:0] above_sync_reg;
    logic irq_mask_reg;
    logic dp_valid_reg;
    logic dp_write_reg;
    logic [7:0] dp_addr_reg;
    logic rd_stage_reg;
    logic [31:0] hrdata_reg;
    logic [7:0] rd_mux;
    logic bus_take;
    logic wr_en;
    logic osc_run;
    logic wait_go;
    logic stop_go;
    logic wait_wake;
    logic stop_wake;
    logic rec_start;
    logic rec_done;
    logic mon_run;
    logic [REC_W-1:0] rec_len_reg;
    logic rec_short_reg;

    assign osc_run = cfg2_reg[`LPM_CFG2_OSC_RUN];

    // Bus slave: writes finish with no wait, reads take one wait state
    assign bus_take = hsel && hready && htrans[1];
    assign wr_en = dp_valid_reg && dp_write_reg;
    assign hreadyout = !(dp_valid_reg && !dp_write_reg && !rd_stage_reg);
    assign hresp = 1'b0;
    assign hrdata = hrdata_reg;

    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            dp_valid_reg <= 1'b0;
            dp_write_reg <= 1'b0;
            dp_addr_reg <= 8'h00;
            rd_stage_reg <= 1'b0;
        end else if (clk_en) begin
            if (hready) begin
                dp_valid_reg <= bus_take;
                dp_write_reg <= hwrite;
                dp_addr_reg <= haddr[7:0];
                rd_stage_reg <= 1'b0;
            end else if (dp_valid_reg && !dp_write_reg) begin
                rd_stage_reg <= 1'b1;
            end
        end
    end

    // Read data sampled after any preceding write has landed
    always_comb begin
        case (dp_addr_reg)
            `LPM_OFS_STATUS: rd_mux = {2'b00, state_reg, 2'b00, mon_run, supply_low_flag};
            `LPM_OFS_CFG_ONE: rd_mux = cfg1_reg;
            `LPM_OFS_CFG_TWO: rd_mux = cfg2_reg;
            `LPM_OFS_IRQ_MASK: rd_mux = mask_reg;
            `LPM_OFS_CLKGEN: rd_mux = clkgen_reg;
            `LPM_OFS_BREAK: rd_mux = {7'h00, brk_flag_reg};
            default: rd_mux = 8'h00;
        endcase
    end

    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            hrdata_reg <= 32'h0000_0000;
        end else if (clk_en && dp_valid_reg && !dp_write_reg && !rd_stage_reg) begin
            hrdata_reg <= {24'h00_0000, rd_mux};
        end
    end

    // Configuration and mask registers
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            cfg1_reg <= `LPM_CFG1_RESET;
            cfg2_reg <= `LPM_CFG2_RESET;
            mask_reg <= `LPM_MASK_RESET;
        end else if (clk_en && wr_en) begin
            if (dp_addr_reg == `LPM_OFS_CFG_ONE) begin
                cfg1_reg <= hwdata[7:0] & `LPM_CFG1_WMASK;
            end
            if (dp_addr_reg == `LPM_OFS_CFG_TWO) begin
                cfg2_reg <= hwdata[7:0] & `LPM_CFG2_WMASK;
            end
            if (dp_addr_reg == `LPM_OFS_IRQ_MASK) begin
                mask_reg <= hwdata[7:0] & `LPM_MASK_WMASK;
            end
        end
    end

    // Clock generator status; stop without oscillator wipes it
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            clkgen_reg <= `LPM_CLKGEN_RESET;
        end else if (clk_en) begin
            if (state_reg == lpm_pkg::ST_STOP && !osc_run) begin
                clkgen_reg <= 8'h00;
            end else begin
                if (wr_en && dp_addr_reg == `LPM_OFS_CLKGEN) begin
                    clkgen_reg[`LPM_CG_CLOCK_MONITOR_ON] <= hwdata[`LPM_CG_CLOCK_MONITOR_ON];
                    clkgen_reg[`LPM_CG_CLOCK_MONITOR_IRQ_EN] <= hwdata[`LPM_CG_CLOCK_MONITOR_IRQ_EN];
                    if (hwdata[`LPM_CG_CMF]) begin
                        clkgen_reg[`LPM_CG_CMF] <= 1'b0;
                    end
                end
                // Later assignments let a same-cycle event beat the clear
                if (ext_clock_stable_set) begin
                    clkgen_reg[`LPM_CG_EXT_STABLE] <= 1'b1;
                end
                if (int_clock_stable_set) begin
                    clkgen_reg[`LPM_CG_INT_STABLE] <= 1'b1;
                end
                if (clock_monitor_event && clkgen_reg[`LPM_CG_CLOCK_MONITOR_ON]) begin
                    clkgen_reg[`LPM_CG_CMF] <= 1'b1;
                end
            end
        end
    end

    // Break-in-low-power flag, write one to clear, set wins
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            brk_flag_reg <= 1'b0;
        end else if (clk_en) begin
            if (wake_req.break_irq && state_reg != lpm_pkg::ST_RUN) begin
                brk_flag_reg <= 1'b1;
            end else if (wr_en && dp_addr_reg == `LPM_OFS_BREAK && hwdata[`LPM_BRK_FLAG]) begin
                brk_flag_reg <= 1'b0;
            end
        end
    end

    // Supply comparator synchronisers
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            below_sync_reg <= 2'b00;
            above_sync_reg <= 2'b00;
        end else if (clk_en) begin
            below_sync_reg <= {below_sync_reg[0], supply_below_fall};
            above_sync_reg <= {above_sync_reg[0], supply_above_rise};
        end
    end

    // Monitor powered unless disabled; in stop only with its enable
    assign mon_run = !cfg1_reg[`LPM_CFG1_MON_PWR_DIS]
        && (state_reg != lpm_pkg::ST_STOP || cfg1_reg[`LPM_CFG1_MON_IN_STOP]);

    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            supply_low_flag <= 1'b0;
        end else if (clk_en && mon_run) begin
            if (below_sync_reg[1]) begin
                supply_low_flag <= 1'b1;
            end else if (above_sync_reg[1]) begin
                supply_low_flag <= 1'b0;
            end
        end
    end

    // Reset request only; the monitor has no interrupt path
    assign supply_reset_req = mon_run && !cfg1_reg[`LPM_CFG1_MON_RST_DIS]
        && supply_low_flag;

    // Wake decode
    assign wait_go = state_reg == lpm_pkg::ST_RUN && wait_exec;
    assign stop_go = state_reg == lpm_pkg::ST_RUN && stop_exec && !wait_exec
        && cfg1_reg[`LPM_CFG1_STOP_EN];
    assign wait_wake = (wake_req.ext_irq && !mask_reg[`LPM_MASK_EXT])
        || (wake_req.keypad_irq && !mask_reg[`LPM_MASK_KEY])
        || wake_req.converter_irq
        || wake_req.break_irq
        || wake_req.clockgen_irq
        || wake_req.serial_irq
        || wake_req.spi_irq
        || wake_req.timebase_irq;
    // Clock generator requests are left out here on purpose
    assign stop_wake = (wake_req.ext_irq && !mask_reg[`LPM_MASK_EXT])
        || (wake_req.keypad_irq && !mask_reg[`LPM_MASK_KEY])
        || wake_req.break_irq
        || (wake_req.timebase_irq && osc_run);
    assign rec_start = state_reg == lpm_pkg::ST_STOP && stop_wake;

    always_comb begin
        state_next = state_reg;
        unique case (state_reg)
            lpm_pkg::ST_RUN: begin
                if (wait_go) begin
                    state_next = lpm_pkg::ST_WAIT;
                end else if (stop_go) begin
                    state_next = lpm_pkg::ST_STOP;
                end
            end
            lpm_pkg::ST_WAIT: begin
                if (wait_wake) begin
                    state_next = lpm_pkg::ST_RUN;
                end
            end
            lpm_pkg::ST_STOP: begin
                if (stop_wake) begin
                    state_next = lpm_pkg::ST_RECOVER;
                end
            end
            lpm_pkg::ST_RECOVER: begin
                if (rec_done) begin
                    state_next = lpm_pkg::ST_RUN;
                end
            end
        endcase
    end

    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            state_reg <= lpm_pkg::ST_RUN;
        end else if (clk_en) begin
            state_reg <= state_next;
        end
    end

    recovery_counter #(
        .WIDTH(REC_W),
        .LONG_COUNT(RECOVERY_LONG),
        .SHORT_COUNT(RECOVERY_SHORT)
    ) u_recovery (
        .clock(clock),
        .rst(rst),
        .clk_en(clk_en),
        .start(rec_start),
        .short_sel(cfg1_reg[`LPM_CFG1_SHORT_REC]),
        .busy(),
        .done(rec_done)
    );

    // Gates and indications follow the next state so they switch on the entry edge
    always_comb begin
        gate_next = '0;
        mode_next = '0;
        unique case (state_next)
            lpm_pkg::ST_RUN: begin
                gate_next = '1;
            end
            lpm_pkg::ST_WAIT: begin
                gate_next = '1;
                gate_next.cpu = 1'b0;
            end
            lpm_pkg::ST_STOP: begin
                gate_next.bus = osc_run;
                gate_next.reference = osc_run;
                gate_next.system = osc_run;
                gate_next.timebase = osc_run;
            end
            lpm_pkg::ST_RECOVER: begin
                gate_next.reference = 1'b1;
            end
        endcase
        mode_next.wait_ind = state_next == lpm_pkg::ST_WAIT;
        mode_next.stop_ind = state_next == lpm_pkg::ST_STOP;
        mode_next.converter_run = state_next != lpm_pkg::ST_STOP;
        mode_next.converter_abort = stop_go;
        mode_next.break_active = state_next != lpm_pkg::ST_STOP;
        mode_next.serial_run = state_next != lpm_pkg::ST_STOP;
        mode_next.spi_run = state_next != lpm_pkg::ST_STOP;
        mode_next.watchdog_run = state_next != lpm_pkg::ST_STOP;
        mode_next.watchdog_prescaler_clr = state_next == lpm_pkg::ST_STOP;
        mode_next.supply_monitor_run = !cfg1_reg[`LPM_CFG1_MON_PWR_DIS]
            && (state_next != lpm_pkg::ST_STOP || cfg1_reg[`LPM_CFG1_MON_IN_STOP]);
    end

    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            clk_gate <= '1;
            periph_mode <= '0;
        end else if (clk_en) begin
            clk_gate <= gate_next;
            periph_mode <= mode_next;
        end
    end

    // CPU interrupt mask: reset sets it, low-power entry clears it
    assign cpu_irq_mask = irq_mask_reg;

    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            irq_mask_reg <= 1'b1;
        end else if (clk_en) begin
            if (wait_go || stop_go) begin
                irq_mask_reg <= 1'b0;
            end else if (cpu_irq_mask_set) begin
                irq_mask_reg <= 1'b1;
            end else if (cpu_irq_mask_clr) begin
                irq_mask_reg <= 1'b0;
            end
        end
    end

    // Helper: length of each recovery window
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            rec_len_reg <= '0;
            rec_short_reg <= 1'b0;
        end else if (clk_en) begin
            rec_len_reg <= (state_reg == lpm_pkg::ST_RECOVER) ? rec_len_reg + 1'b1 : '0;
            if (rec_start) begin
                rec_short_reg <= cfg1_reg[`LPM_CFG1_SHORT_REC];
            end
        end
    end

    default clocking cb @(posedge clock);
    endclocking
    default disable iff (rst);

    AST_FLAG_SET: assert property (
        (clk_en && mon_run && below_sync_reg[1]) |=> supply_low_flag)
        else $error("supply flag not set below falling trip");
    AST_FLAG_HOLD: assert property (
        (clk_en && mon_run && !below_sync_reg[1] && !above_sync_reg[1])
        |=> $stable(supply_low_flag))
        else $error("supply flag changed between trips");
    AST_WAIT_CLOCKS: assert property (
        (state_reg == lpm_pkg::ST_WAIT) |-> (!clk_gate.cpu && clk_gate.bus))
        else $error("wait clock gating wrong");
    AST_STOP_CLOCKS: assert property (
        (clk_en && stop_go && !osc_run)
        |=> (!clk_gate.cpu && !clk_gate.bus && !clk_gate.reference && !clk_gate.watchdog))
        else $error("stop clock gating wrong");
    AST_STOP_REFUSED: assert property (
        (clk_en && state_reg == lpm_pkg::ST_RUN && stop_exec && !wait_exec
        && !cfg1_reg[`LPM_CFG1_STOP_EN]) |=> state_reg == lpm_pkg::ST_RUN)
        else $error("stop taken while disabled");
    AST_MASK_CLEARED: assert property (
        (clk_en && (wait_go || stop_go)) |=> !cpu_irq_mask)
        else $error("mask not cleared on low-power entry");
    AST_RECOVERY_LEN: assert property (
        $fell(state_reg == lpm_pkg::ST_RECOVER)
        |-> rec_len_reg == (rec_short_reg ? REC_W'(RECOVERY_SHORT) : REC_W'(RECOVERY_LONG)))
        else $error("recovery window length wrong");
    AST_CPU_HELD: assert property (
        (state_reg == lpm_pkg::ST_RECOVER) |-> (!clk_gate.cpu && !clk_gate.bus))
        else $error("clocks running during recovery");
    AST_CLKGEN_WIPE: assert property (
        (clk_en && state_reg == lpm_pkg::ST_STOP && !osc_run)
        |=> clkgen_reg == 8'h00)
        else $error("clock generator bits survived stop");
    AST_BREAK_WAKE: assert property (
        (clk_en && state_reg == lpm_pkg::ST_STOP && wake_req.break_irq)
        |=> (brk_flag_reg && state_reg == lpm_pkg::ST_RECOVER))
        else $error("break did not end stop");
    AST_STOP_ENTRY: assert property (
        (clk_en && stop_go) |=> (periph_mode.stop_ind && periph_mode.converter_abort
        && !periph_mode.wait_ind) ##1 (!clk_en || !periph_mode.converter_abort))
        else $error("stop indications wrong");
    AST_SPI_WAKE: assert property (
        (clk_en && state_reg == lpm_pkg::ST_WAIT && wake_req.spi_irq)
        |=> state_reg == lpm_pkg::ST_RUN)
        else $error("spi request did not end wait");

    COV_WAIT_EXIT: cover property (state_reg == lpm_pkg::ST_WAIT ##1 state_reg == lpm_pkg::ST_RUN);
    COV_STOP_ENTRY: cover property (clk_en && stop_go);
    COV_RECOVER_DONE: cover property ($fell(state_reg == lpm_pkg::ST_RECOVER));
    COV_FLAG_SET: cover property ($rose(supply_low_flag));
endmodule
`default_nettype wire

// >>> pkg/lpm_map.svh
// Register offsets, field positions, reset values and counts of the low-power controller
// Notes on behaviour
// - Supply-low flag read-only, sets below falling trip
// - Any reset clears the supply-low flag
// - Flag clears above rising trip, else holds
// - Supply monitor never raises an interrupt
// - Enabled supply monitor keeps running in wait
// - Supply monitor runs in stop only if enabled
// - Stop stops CPU clock; bus clock unless oscillator-run
// - Converter runs in wait, aborts on stop
// - Break idle in stop; break wake sets flag
// - Wait clears CPU mask; reset sets it
// - Stop clears CPU mask; reset sets it
// - CPU clock restarts only after stabilization delay
// - Oscillator off in stop holds generator clocks low
// - Oscillator on in stop; generator irqs cannot wake
// - Stop without oscillator clears stable and monitor bits
// - Watchdog counts in wait; stop removes its clock
// - Stop honoured only with stop-enable bit set
// - Unmasked external interrupt wakes wait and stop
// - Unmasked keypad interrupt wakes wait and stop
// - Serial runs in wait, frozen in stop
// - SPI runs in wait, its irqs wake
// - Recovery holds clocks 4096 cycles, or 32
`ifndef LPM_MAP_SVH
`define LPM_MAP_SVH
`define LPM_OFS_STATUS 8'h00
`define LPM_OFS_CFG_ONE 8'h04
`define LPM_OFS_CFG_TWO 8'h08
`define LPM_OFS_IRQ_MASK 8'h0c
`define LPM_OFS_CLKGEN 8'h10
`define LPM_OFS_BREAK 8'h14
`define LPM_CFG1_STOP_EN 0
`define LPM_CFG1_SHORT_REC 1
`define LPM_CFG1_MON_IN_STOP 2
`define LPM_CFG1_MON_PWR_DIS 3
`define LPM_CFG1_MON_RST_DIS 4
`define LPM_CFG1_WMASK 8'h1f
`define LPM_CFG2_OSC_RUN 0
`define LPM_CFG2_WMASK 8'h01
`define LPM_MASK_EXT 0
`define LPM_MASK_KEY 1
`define LPM_MASK_WMASK 8'h03
`define LPM_CG_EXT_STABLE 0
`define LPM_CG_INT_STABLE 1
`define LPM_CG_CLOCK_MONITOR_ON 2
`define LPM_CG_CLOCK_MONITOR_IRQ_EN 3
`define LPM_CG_CMF 4
`define LPM_BRK_FLAG 0
`define LPM_CFG1_RESET 8'h00
`define LPM_CFG2_RESET 8'h00
`define LPM_MASK_RESET 8'h00
`define LPM_CLKGEN_RESET 8'h00
`define LPM_RECOVERY_LONG 4096
`define LPM_RECOVERY_SHORT 32
`endif

// >>> pkg/lpm_pkg.sv
// Types shared by the low-power mode controller
package lpm_pkg;
    typedef enum logic [1:0] {
        ST_RUN = 2'b00,
        ST_WAIT = 2'b01,
        ST_STOP = 2'b10,
        ST_RECOVER = 2'b11
    } lpm_state_t;

    typedef struct packed {
        logic ext_irq;
        logic keypad_irq;
        logic converter_irq;
        logic break_irq;
        logic clockgen_irq;
        logic serial_irq;
        logic spi_irq;
        logic timebase_irq;
    } wake_req_t;

    typedef struct packed {
        logic cpu;
        logic bus;
        logic reference;
        logic system;
        logic watchdog;
        logic timebase;
    } clk_gate_t;

    typedef struct packed {
        logic wait_ind;
        logic stop_ind;
        logic converter_run;
        logic converter_abort;
        logic break_active;
        logic serial_run;
        logic spi_run;
        logic watchdog_run;
        logic watchdog_prescaler_clr;
        logic supply_monitor_run;
    } periph_mode_t;
endpackage

// >>> src/recovery_counter.sv
// Stop-recovery delay counter
`timescale 1ns/1ps
`default_nettype none
module recovery_counter #(
    parameter int WIDTH = 13,
    parameter int LONG_COUNT = 4096,
    parameter int SHORT_COUNT = 32
) (
    // Clock and reset
    input wire logic clock,
    input wire logic rst,
    input wire logic clk_en,
    // Control
    input wire logic start,
    input wire logic short_sel,
    // Status
    output logic busy,
    output logic done
);
    logic [WIDTH-1:0] count_reg;
    logic busy_reg;

    assign busy = busy_reg;
    assign done = busy_reg && (count_reg == '0);

    // Loaded with count less one so the busy window is exactly the count
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            count_reg <= '0;
            busy_reg <= 1'b0;
        end else if (clk_en) begin
            if (start) begin
                busy_reg <= 1'b1;
                count_reg <= short_sel ? WIDTH'(SHORT_COUNT - 1) : WIDTH'(LONG_COUNT - 1);
            end else if (done) begin
                busy_reg <= 1'b0;
            end else if (busy_reg) begin
                count_reg <= count_reg - 1'b1;
            end
        end
    end

    AST_COUNT_LOAD: assert property (@(posedge clock) disable iff (rst)
        (clk_en && start) |=> busy_reg && !done)
        else $error("recovery counter not loaded on start");
endmodule
`default_nettype wire

// >>> tb/cpu_periph_model.sv
// CPU and peripheral stand-in: instruction pulses and wake requests
`timescale 1ns/1ps
`default_nettype none
module cpu_periph_model (
    // Clock
    input wire logic clock,
    // Toward the controller
    output logic wait_exec,
    output logic stop_exec,
    output lpm_pkg::wake_req_t wake_req,
    output logic ext_stable_set
);
    initial begin
        wait_exec = 1'h0;
        stop_exec = 1'h0;
        wake_req = '0;
        ext_stable_set = 1'h0;
    end
    // One-cycle instruction pulse
    task automatic instr(input logic w, input logic s);
        wait_exec <= w;
        stop_exec <= s;
        @(posedge clock);
        wait_exec <= 1'h0;
        stop_exec <= 1'h0;
    endtask
    // Source drops its request once served, so one cycle is enough
    task automatic wake(input lpm_pkg::wake_req_t v);
        wake_req <= v;
        @(posedge clock);
        wake_req <= '0;
    endtask
    task automatic stable_pulse();
        ext_stable_set <= 1'h1;
        @(posedge clock);
        ext_stable_set <= 1'h0;
    endtask
endmodule
`default_nettype wire

// >>> tb/low_power_mode_control_tb_top.sv
// Self-checking bench for the low-power mode controller
`timescale 1ns/1ps
`default_nettype none
module low_power_mode_control_tb_top;
    localparam int LONG_N = 64;
    localparam int SHORT_N = 4;
    logic clock = 1'h0;
    logic rst = 1'h1;
    logic hsel = 1'h0;
    logic [31:0] haddr = 32'h0;
    logic [1:0] htrans = 2'h0;
    logic hwrite = 1'h0;
    logic [2:0] hsize = 3'h2;
    logic [31:0] hwdata = 32'h0;
    logic below = 1'h0;
    logic above = 1'h1;
    logic snap = 1'h0;
    logic rd_dp = 1'h0;
    logic en = 1'h1;
    logic hreadyout, hresp, cpu_irq_mask, supply_reset_req, wait_exec, stop_exec, ext_set;
    logic [31:0] hrdata, rv;
    logic [19:0] vec;
    logic [63:0] e;
    logic [63:0] q[$];
    lpm_pkg::wake_req_t wake_req;
    lpm_pkg::clk_gate_t clk_gate;
    lpm_pkg::periph_mode_t periph_mode;
    int n_errors = 0;
    int num_checks = 0;
    int cyc = 0;
    int seed = 32'hefd9;
    always #2.5 clock = ~clock;
    low_power_mode_control #(.RECOVERY_LONG(LONG_N), .RECOVERY_SHORT(SHORT_N))
        low_power_mode_control_inst (.clock(clock), .rst(rst), .clk_en(en), .hsel(hsel),
        .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
        .hready(hreadyout), .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata),
        .wait_exec(wait_exec), .stop_exec(stop_exec), .cpu_irq_mask_set(1'h0),
        .cpu_irq_mask_clr(1'h0), .cpu_irq_mask(cpu_irq_mask), .wake_req(wake_req),
        .ext_clock_stable_set(ext_set), .int_clock_stable_set(1'h0),
        .clock_monitor_event(1'h0), .supply_below_fall(below), .supply_above_rise(above),
        .supply_reset_req(supply_reset_req), .clk_gate(clk_gate), .periph_mode(periph_mode));
    cpu_periph_model cpu_periph_model_inst (.clock(clock), .wait_exec(wait_exec),
        .stop_exec(stop_exec), .wake_req(wake_req), .ext_stable_set(ext_set));
    assign vec = {hresp, supply_reset_req, periph_mode.converter_abort,
        periph_mode.break_active, periph_mode.serial_run, periph_mode.spi_run,
        periph_mode.watchdog_prescaler_clr, 1'h0, cpu_irq_mask, clk_gate,
        periph_mode.wait_ind, periph_mode.stop_ind, periph_mode.converter_run,
        periph_mode.watchdog_run, periph_mode.supply_monitor_run};
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        num_checks++;
        if (seen !== exp) begin
            n_errors++;
            $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    task automatic results();
        $display("checks=%0d errors=%0d", num_checks, n_errors);
        if (n_errors == 0 && num_checks > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask
    // Address phase held until hready, then data phase until hready
    task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d);
        hsel <= 1'h1;
        hsize <= 3'h2;
        haddr <= {24'h0, a};
        htrans <= 2'h2;
        hwrite <= wr;
        @(posedge clock);
        while (!hreadyout) @(posedge clock);
        htrans <= 2'h0;
        hwdata <= d;
        @(posedge clock);
        while (!hreadyout) @(posedge clock);
    endtask
    task automatic rd(input logic [7:0] a, input logic [31:0] care, input logic [31:0] x);
        q.push_back({care, x});
        bus(1'h0, a, 32'h0);
    endtask
    task automatic chk(input logic [19:0] care, input logic [19:0] x);
        q.push_back({12'h0, care, 12'h0, x});
        snap <= 1'h1;
        @(posedge clock);
        snap <= 1'h0;
    endtask
    // Comparator levels pass two sync stages and the flag: four edges is ample
    task automatic sup(input logic b, input logic a, input logic [31:0] x);
        below <= b;
        above <= a;
        repeat (4) @(posedge clock);
        rd(8'h00, 32'h1, x);
    endtask
    always @(posedge clock) begin
        if (rd_dp && hreadyout) begin
            e = q.pop_front();
            check(hrdata & e[63:32], e[31:0]);
        end
        if (snap) begin
            e = q.pop_front();
            check({12'h0, vec} & e[63:32], e[31:0]);
        end
        if (hsel && htrans[1] && hreadyout) rd_dp <= !hwrite;
        else if (hreadyout) rd_dp <= 1'h0;
        cyc <= cyc + 1;
        if (cyc == 5000) begin
            n_errors++;
            results();
        end
    end
    initial begin
        repeat (4) @(posedge clock);
        rst <= 1'h0;
        @(posedge clock);
        chk(20'hfffff, 20'h1cfe7);
        rd(8'h00, 32'h31, 32'h0);
        rd(8'h1c, 32'hffffffff, 32'h0);
        rv = $random(seed);
        bus(1'h1, 8'h0c, rv);
        rd(8'h0c, 32'hffffffff, {30'h0, rv[1:0]});
        bus(1'h1, 8'h0c, 32'h0);
        sup(1'h1, 1'h0, 32'h1);
        sup(1'h0, 1'h0, 32'h1);
        sup(1'h0, 1'h1, 32'h0);
        sup(1'h1, 1'h0, 32'h1);
        chk(20'hc0000, 20'h40000);
        // Reset out of wait while the flag is set
        cpu_periph_model_inst.instr(1'h1, 1'h0);
        below <= 1'h0;
        rst <= 1'h1;
        repeat (2) @(posedge clock);
        rst <= 1'h0;
        repeat (2) @(posedge clock);
        chk(20'hfffff, 20'h1cfe7);
        rd(8'h00, 32'h31, 32'h0);
        cpu_periph_model_inst.instr(1'h0, 1'h1);
        chk(20'hfffff, 20'h1cfe7);
        for (int i = 0; i < 8; i++) begin
            cpu_periph_model_inst.instr(1'h1, 1'h0);
            chk(20'hfffff, 20'h1c3f7);
            cpu_periph_model_inst.wake(8'h80 >> i);
            chk(20'hfffff, 20'h1c7e7);
        end
        // Frozen clock enable: a wake request must not be taken
        cpu_periph_model_inst.instr(1'h1, 1'h0);
        en <= 1'h0;
        cpu_periph_model_inst.wake(8'h80);
        en <= 1'h1;
        chk(20'hfffff, 20'h1c3f7);
        cpu_periph_model_inst.wake(8'h80);
        bus(1'h1, 8'h10, 32'h0c);
        cpu_periph_model_inst.stable_pulse();
        rd(8'h10, 32'hff, 32'h0d);
        // Oscillator off with long recovery, then on with short recovery
        for (int k = 0; k < 2; k++) begin
            bus(1'h1, 8'h04, {30'h0, k[0], 1'h1});
            bus(1'h1, 8'h08, {31'h0, k[0]});
            cpu_periph_model_inst.instr(1'h0, 1'h1);
            chk(20'hfffff, k ? 20'h223a8 : 20'h22008);
            cpu_periph_model_inst.wake(8'h08);
            chk(20'hfffff, k ? 20'h023a8 : 20'h02008);
            cpu_periph_model_inst.wake(k ? 8'h01 : 8'h90);
            chk(20'hfffe0, 20'h1c100);
            repeat ((k ? SHORT_N : LONG_N) - 2) @(posedge clock);
            chk(20'hfffe0, 20'h1c100);
            chk(20'hfffe0, 20'h1c7e0);
        end
        rd(8'h10, 32'hff, 32'h0);
        repeat (2) @(posedge clock);
        results();
    end
endmodule
`default_nettype wire
